// >>> include/mem_sampler_pkg.sv
// constants, types and field layout of the precise memory event sampler
// assumes one retirement report per clk_sys cycle, already committed
//
// Overview of operation
// RULE1 - overflow arms; next event captures, then interrupts
// RULE2 - sample address is the following instruction
// RULE3 - count only at retirement, never speculatively
// RULE4 - capture all sixteen registers after completion
// RULE5 - all four counters sample independently; here one shared record, lowest counter wins
// RULE6 - select 0b: 01 loads, 02 stores
// RULE7 - select cb: 01/02/04/08/10 load data sources
// RULE8 - select cb 20: loads dropped by breakpoint
// RULE9 - select cb 40: loads hitting fill buffer
// RULE10 - select cb 80: every load data tlb miss
// RULE11 - select 0f: 02/08/10/20/80 uncore sources
// RULE12 - remote modified line counts as home memory
// RULE13 - select 0c: 01 store tlb miss, 02 dropped
// RULE14 - select c8 20: instruction tlb miss retired
// RULE15 - load source events count demand loads only
// RULE16 - unsnooped last-level hit by presence bits
`default_nettype none
package mem_sampler_pkg;
  localparam int unsigned NUM_CNT = 4;
  localparam int unsigned NUM_GPR = 16;
  localparam int unsigned CNT_W   = 32;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam logic [CNT_W-1:0] CNT_MAX = 32'hffff_ffff;

  // event selects
  localparam logic [7:0] EVSEL_MEM_INSTR  = 8'h0b;
  localparam logic [7:0] EVSEL_LOAD_SRC   = 8'hcb;
  localparam logic [7:0] EVSEL_UNCORE_SRC = 8'h0f;
  localparam logic [7:0] EVSEL_STORE      = 8'h0c;
  localparam logic [7:0] EVSEL_ITLB       = 8'hc8;
  // unit masks
  localparam logic [7:0] UM_LOADS        = 8'h01;
  localparam logic [7:0] UM_STORES       = 8'h02;
  localparam logic [7:0] UM_L1_HIT       = 8'h01;
  localparam logic [7:0] UM_L2_HIT       = 8'h02;
  localparam logic [7:0] UM_NOSNOOP      = 8'h04;
  localparam logic [7:0] UM_SIB_SNOOP    = 8'h08;
  localparam logic [7:0] UM_LLC_MISS     = 8'h10;
  localparam logic [7:0] UM_LD_DROPPED   = 8'h20;
  localparam logic [7:0] UM_FILL_BUF     = 8'h40;
  localparam logic [7:0] UM_LD_DTLB      = 8'h80;
  localparam logic [7:0] UM_SIB_HITM     = 8'h02;
  localparam logic [7:0] UM_REMOTE_CACHE = 8'h08;
  localparam logic [7:0] UM_REMOTE_DRAM  = 8'h10;
  localparam logic [7:0] UM_LOCAL_DRAM   = 8'h20;
  localparam logic [7:0] UM_UNCACHED_IO  = 8'h80;
  localparam logic [7:0] UM_ST_DTLB      = 8'h01;
  localparam logic [7:0] UM_ST_DROPPED   = 8'h02;
  localparam logic [7:0] UM_ITLB         = 8'h20;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CFG0   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CNT0   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IP_LO  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_IP_HI  = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_GPR0   = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_GPR_END = 8'hc0;
  // field positions
  localparam int unsigned CFG_EVSEL_LSB = 0;
  localparam int unsigned CFG_UMASK_LSB = 8;
  localparam int unsigned CFG_EN_BIT    = 16;
  localparam int unsigned ST_ARMED_LSB  = 0;
  localparam int unsigned ST_PEND_BIT   = 8;
  localparam int unsigned ST_SRC_LSB    = 12;

  typedef enum logic [3:0] {
    SRC_L1          = 4'h0,
    SRC_FILL_BUF    = 4'h1,
    SRC_L2          = 4'h2,
    SRC_LLC         = 4'h3,
    SRC_REMOTE_FWD  = 4'h4,
    SRC_LOCAL_DRAM  = 4'h5,
    SRC_REMOTE_DRAM = 4'h6,
    SRC_REMOTE_HITM = 4'h7,
    SRC_UNCACHED_IO = 4'h8
  } data_src_t;

  typedef enum logic {
    ST_COUNT = 1'b0,
    ST_ARMED = 1'b1
  } cnt_state_t;

  typedef struct packed {
    logic        en;
    logic [7:0]  umask;
    logic [7:0]  evsel;
  } cnt_cfg_t;

  // one committed instruction from retirement
  typedef struct packed {
    logic        valid;
    logic        is_load;
    logic        is_store;
    logic        demand;
    logic        dtlb_miss;
    logic        itlb_miss;
    logic        bp_dropped;
    data_src_t   src;
    logic [3:0]  presence;
    logic [3:0]  self_core;
    logic        llc_wb_mod;
    logic        sib_modified;
    logic        home_local;
    logic [63:0] next_ip;
  } retire_t;

  typedef logic [NUM_GPR-1:0][63:0] gpr_file_t;
endpackage : mem_sampler_pkg
`default_nettype wire

// >>> hw/mem_event_sampler.sv
// precise memory event sampler: four event counters and one sample record
// assumes retire_info reports only committed instructions, one per cycle
//
// Chosen here: the address-and-strobe port and the address map.
`default_nettype none
module mem_event_sampler (
  input  wire logic                               clk_sys,
  input  wire logic                               sys_rst,
  input  wire mem_sampler_pkg::retire_t           retire_info,
  input  wire mem_sampler_pkg::gpr_file_t         retire_gpr,
  input  wire logic [mem_sampler_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [mem_sampler_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [mem_sampler_pkg::DATA_W-1:0] reg_rdata,
  output logic                                    perf_monitor_interrupt
);
  import mem_sampler_pkg::*;

  // ---------------------------------------------------------------
  // event classification
  // ---------------------------------------------------------------
  function automatic logic evt_hit(input cnt_cfg_t c, input retire_t r);
    logic [7:0] cls;
    logic       ld;
    logic       llc_hit;
    logic       only_self;
    logic       shared;
    logic       nosnoop;
    logic       beyond_llc;
    logic       loc_mem;
    logic       rem_mem;
    cls        = 8'h00;
    ld         = r.is_load & r.demand; // RULE15
    llc_hit    = (r.src == SRC_LLC);
    only_self  = (r.presence == r.self_core);
    shared     = ($countones(r.presence) > 1);
    nosnoop    = llc_hit & (only_self | shared | r.llc_wb_mod); // RULE16
    beyond_llc = (r.src >= SRC_REMOTE_FWD);
    loc_mem    = (r.src == SRC_LOCAL_DRAM) |
                 ((r.src == SRC_REMOTE_HITM) & r.home_local); // RULE12
    rem_mem    = (r.src == SRC_REMOTE_DRAM) |
                 ((r.src == SRC_REMOTE_HITM) & ~r.home_local); // RULE12
    case (c.evsel)
      EVSEL_MEM_INSTR: begin
        cls = ({8{r.is_load}} & UM_LOADS) | ({8{r.is_store}} & UM_STORES); // RULE6
      end
      EVSEL_LOAD_SRC: begin
        cls = ({8{ld & (r.src == SRC_L1)}} & UM_L1_HIT) | // RULE7
              ({8{ld & (r.src == SRC_L2)}} & UM_L2_HIT) | // RULE7
              ({8{ld & nosnoop}} & UM_NOSNOOP) | // RULE7
              ({8{ld & llc_hit & ~nosnoop}} & UM_SIB_SNOOP) | // RULE7
              ({8{ld & beyond_llc}} & UM_LLC_MISS) | // RULE7
              ({8{ld & r.bp_dropped}} & UM_LD_DROPPED) | // RULE8
              ({8{ld & (r.src == SRC_FILL_BUF)}} & UM_FILL_BUF) | // RULE9
              ({8{r.is_load & r.dtlb_miss}} & UM_LD_DTLB); // RULE10
      end
      EVSEL_UNCORE_SRC: begin
        cls = ({8{ld & llc_hit & ~nosnoop & r.sib_modified}} & UM_SIB_HITM) | // RULE11
              ({8{ld & (r.src == SRC_REMOTE_FWD)}} & UM_REMOTE_CACHE) | // RULE11
              ({8{ld & rem_mem}} & UM_REMOTE_DRAM) | // RULE11
              ({8{ld & loc_mem}} & UM_LOCAL_DRAM) | // RULE11
              ({8{ld & (r.src == SRC_UNCACHED_IO)}} & UM_UNCACHED_IO); // RULE11
      end
      EVSEL_STORE: begin
        cls = ({8{r.is_store & r.dtlb_miss}} & UM_ST_DTLB) | // RULE13
              ({8{r.is_store & r.bp_dropped}} & UM_ST_DROPPED); // RULE13
      end
      EVSEL_ITLB: begin
        cls = {8{r.itlb_miss}} & UM_ITLB; // RULE14
      end
      default: begin
        cls = 8'h00;
      end
    endcase
    return c.en & r.valid & (|(cls & c.umask)); // RULE3
  endfunction : evt_hit

  function automatic logic in_block(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base);
    return a[ADDR_W-1:4] == base[ADDR_W-1:4];
  endfunction : in_block

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  cnt_cfg_t           cfg_q [NUM_CNT];
  logic [CNT_W-1:0]   cnt_q [NUM_CNT];
  cnt_state_t         st_q  [NUM_CNT];
  logic [NUM_CNT-1:0] hit;
  logic [NUM_CNT-1:0] trig;
  logic [NUM_CNT-1:0] grant;
  logic [NUM_CNT-1:0] cnt_wr;
  logic               pend_q;
  logic               cap;
  logic               pend_clr;
  logic [1:0]         grant_idx;

  generate
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
      assign hit[i]    = evt_hit(cfg_q[i], retire_info); // RULE5
      assign cnt_wr[i] = reg_wr & in_block(reg_addr, OFS_CNT0) &
                         (reg_addr[3:2] == 2'(i));
      assign trig[i]   = (st_q[i] == ST_ARMED) & hit[i] & ~pend_q; // RULE1

      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          cfg_q[i] <= '0;
        end else if (reg_wr & in_block(reg_addr, OFS_CFG0) & (reg_addr[3:2] == 2'(i))) begin
          cfg_q[i] <= cnt_cfg_t'(reg_wdata[CFG_EN_BIT:CFG_EVSEL_LSB]);
        end
      end

      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          cnt_q[i] <= '0;
        end else if (cnt_wr[i]) begin
          cnt_q[i] <= reg_wdata;
        end else if (hit[i]) begin
          cnt_q[i] <= cnt_q[i] + 1'b1; // RULE3
        end
      end

      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          st_q[i] <= ST_COUNT;
        end else begin
          case (st_q[i])
            ST_COUNT: begin
              if (hit[i] & ~cnt_wr[i] & (cnt_q[i] == CNT_MAX)) begin
                st_q[i] <= ST_ARMED; // RULE1
              end
            end
            ST_ARMED: begin
              if (grant[i] | ~cfg_q[i].en) begin
                st_q[i] <= ST_COUNT;
              end
            end
            default: begin
              st_q[i] <= ST_COUNT;
            end
          endcase
        end
      end
    end
  endgenerate

  // lowest counter wins when several fire on one instruction
  always_comb begin
    grant     = '0;
    grant_idx = 2'h0;
    for (int k = NUM_CNT - 1; k >= 0; k--) begin
      if (trig[k]) begin
        grant     = '0;
        grant[k]  = 1'b1;
        grant_idx = k[1:0];
      end
    end
  end
  assign cap = |trig;

  // ---------------------------------------------------------------
  // sample record
  // ---------------------------------------------------------------
  logic [63:0] ip_q;
  gpr_file_t   gpr_q;
  logic [1:0]  src_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ip_q  <= '0;
      gpr_q <= '0;
      src_q <= 2'h0;
    end else if (cap) begin
      ip_q  <= retire_info.next_ip; // RULE2
      gpr_q <= retire_gpr; // RULE4
      src_q <= grant_idx;
    end
  end

  // interrupt stands until software clears it; no new capture while it stands
  assign pend_clr = reg_wr & (reg_addr == OFS_STATUS) & reg_wdata[ST_PEND_BIT];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= cap | (pend_q & ~pend_clr); // RULE1
    end
  end
  assign perf_monitor_interrupt = pend_q;

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  logic [DATA_W-1:0]  rd_val;
  logic [NUM_CNT-1:0] armed_vec;
  logic [3:0]         gpr_idx;
  logic [ADDR_W-1:0]  gpr_off;

  always_comb begin
    for (int k = 0; k < NUM_CNT; k++) begin
      armed_vec[k] = (st_q[k] == ST_ARMED);
    end
  end
  // register n sits at gpr base plus eight times n
  assign gpr_off = reg_addr - OFS_GPR0;
  assign gpr_idx = gpr_off[6:3];

  always_comb begin
    rd_val = '0;
    if (in_block(reg_addr, OFS_CFG0)) begin
      rd_val[CFG_EN_BIT:CFG_EVSEL_LSB] = cfg_q[reg_addr[3:2]];
    end else if (in_block(reg_addr, OFS_CNT0)) begin
      rd_val = cnt_q[reg_addr[3:2]];
    end else if (reg_addr == OFS_STATUS) begin
      rd_val[ST_ARMED_LSB +: NUM_CNT] = armed_vec;
      rd_val[ST_PEND_BIT]             = pend_q;
      rd_val[ST_SRC_LSB +: 2]         = src_q;
    end else if (reg_addr == OFS_IP_LO) begin
      rd_val = ip_q[31:0];
    end else if (reg_addr == OFS_IP_HI) begin
      rd_val = ip_q[63:32];
    end else if ((reg_addr >= OFS_GPR0) && (reg_addr < OFS_GPR_END)) begin
      rd_val = reg_addr[2] ? gpr_q[gpr_idx][63:32] : gpr_q[gpr_idx][31:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end else begin
      reg_rdata <= '0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_overflow0;
    (st_q[0] == ST_COUNT) && hit[0] && !cnt_wr[0] && (cnt_q[0] == CNT_MAX);
  endsequence
  sequence s_fire0;
    (st_q[0] == ST_ARMED) && hit[0] && !pend_q;
  endsequence

  property p_arm_on_overflow;
    s_overflow0 |=> (st_q[0] == ST_ARMED) && (cnt_q[0] == '0) && !pend_q;
  endproperty
  a_arm_on_overflow: assert property (p_arm_on_overflow) // RULE1
    else $error("counter 0 did not arm on overflow");

  property p_capture_irq;
    s_fire0 |=> perf_monitor_interrupt && (st_q[0] == ST_COUNT) && (src_q == 2'h0);
  endproperty
  a_capture_irq: assert property (p_capture_irq) // RULE1
    else $error("armed event did not capture and interrupt");

  property p_sample_ip;
    cap |=> (ip_q == $past(retire_info.next_ip));
  endproperty
  a_sample_ip: assert property (p_sample_ip) // RULE2
    else $error("sample address is not the following instruction");

  property p_no_spec_count;
    !retire_info.valid && !cnt_wr[1] |=> $stable(cnt_q[1]);
  endproperty
  a_no_spec_count: assert property (p_no_spec_count) // RULE3
    else $error("counter moved without a retirement");

  property p_sample_gpr;
    cap |=> (gpr_q[0] == $past(retire_gpr[0])) && (gpr_q[15] == $past(retire_gpr[15]));
  endproperty
  a_sample_gpr: assert property (p_sample_gpr) // RULE4
    else $error("sample registers differ from completion values");

  property p_count_step;
    hit[3] && !cnt_wr[3] |=> cnt_q[3] == $past(cnt_q[3]) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step) // RULE5
    else $error("counter 3 did not step on its event");

  property p_load_count;
    cfg_q[2].en && (cfg_q[2].evsel == EVSEL_MEM_INSTR) && (cfg_q[2].umask == UM_LOADS)
      && retire_info.valid && retire_info.is_load |-> hit[2];
  endproperty
  a_load_count: assert property (p_load_count) // RULE6
    else $error("retired load not counted");

  property p_irq_holds;
    perf_monitor_interrupt && !pend_clr |=> perf_monitor_interrupt;
  endproperty
  a_irq_holds: assert property (p_irq_holds) // RULE1
    else $error("interrupt dropped without a clear");

  property p_prefetch_excluded;
    cfg_q[0].en && (cfg_q[0].evsel == EVSEL_LOAD_SRC) && (cfg_q[0].umask == UM_L1_HIT)
      && !retire_info.demand |-> !hit[0];
  endproperty
  a_prefetch_excluded: assert property (p_prefetch_excluded) // RULE15
    else $error("non-demand load counted by source");

  property p_nosnoop_hit;
    cfg_q[0].en && (cfg_q[0].evsel == EVSEL_LOAD_SRC) && (cfg_q[0].umask == UM_NOSNOOP)
      && retire_info.valid && retire_info.is_load && retire_info.demand
      && (retire_info.src == SRC_LLC) && (retire_info.presence == retire_info.self_core)
      |-> hit[0];
  endproperty
  a_nosnoop_hit: assert property (p_nosnoop_hit) // RULE16
    else $error("unsnooped last-level hit not counted");

  property p_remote_hitm_home;
    cfg_q[0].en && (cfg_q[0].evsel == EVSEL_UNCORE_SRC) && (cfg_q[0].umask == UM_LOCAL_DRAM)
      && retire_info.valid && retire_info.is_load && retire_info.demand
      && (retire_info.src == SRC_REMOTE_HITM) && retire_info.home_local
      |-> hit[0];
  endproperty
  a_remote_hitm_home: assert property (p_remote_hitm_home) // RULE12
    else $error("remote modified line not counted at its home memory");

  property p_itlb_count;
    cfg_q[0].en && (cfg_q[0].evsel == EVSEL_ITLB) && (cfg_q[0].umask == UM_ITLB)
      && retire_info.valid && retire_info.itlb_miss |-> hit[0];
  endproperty
  a_itlb_count: assert property (p_itlb_count) // RULE14
    else $error("retired instruction tlb miss not counted");

  property p_store_dtlb;
    cfg_q[0].en && (cfg_q[0].evsel == EVSEL_STORE) && (cfg_q[0].umask == UM_ST_DTLB)
      && retire_info.valid && retire_info.is_store && retire_info.dtlb_miss |-> hit[0];
  endproperty
  a_store_dtlb: assert property (p_store_dtlb) // RULE13
    else $error("retired store data tlb miss not counted");
endmodule : mem_event_sampler
`default_nettype wire

// >>> dv/retire_model.sv
// partner model: core retirement logic feeding committed reports to the sampler
// assumes the bench raises send for one clk_sys cycle with the report on ev
`default_nettype none
module retire_model (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        send,
  input  wire mem_sampler_pkg::retire_t    ev,
  output var  mem_sampler_pkg::retire_t    retire_info,
  output var  mem_sampler_pkg::gpr_file_t  retire_gpr
);
  timeunit 1ns;
  timeprecision 1ps;
  import mem_sampler_pkg::*;

  // ----------------------------------------
  // retirement report
  // ----------------------------------------
  // only committed instructions are ever reported; idle ip bits keep toggling
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      retire_info <= '0;
    end else if (send) begin
      retire_info <= ev;
    end else begin
      retire_info.valid   <= 1'b0;
      retire_info.next_ip <= ~retire_info.next_ip;
    end
  end

  // ----------------------------------------
  // register file after completion
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    for (int n = 0; n < NUM_GPR; n++) begin
      if (send) begin
        retire_gpr[n] <= {~ev.next_ip[31:0], ev.next_ip[31:0] + 32'(n)};
      end else begin
        retire_gpr[n] <= ~retire_gpr[n];
      end
    end
  end
endmodule : retire_model
`default_nettype wire

// >>> dv/mem_event_sampler_tb.sv
// testbench: event codes, overflow arming, sample capture and clear
// assumes the sampler package and the retire_model partner are compiled first
`default_nettype none
module mem_event_sampler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mem_sampler_pkg::*;

  logic              clk_sys   = 1'b0;
  logic              sys_rst   = 1'b1;
  retire_t           retire_info;
  gpr_file_t         retire_gpr;
  logic [ADDR_W-1:0] reg_addr  = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              perf_monitor_interrupt;
  logic              send      = 1'b0;
  retire_t           ev        = '0;
  int                num_errors = 0;
  int                num_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  mem_event_sampler mem_event_sampler_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .retire_info(retire_info),
    .retire_gpr(retire_gpr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .perf_monitor_interrupt(perf_monitor_interrupt));

  retire_model retire_model_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .send(send), .ev(ev),
    .retire_info(retire_info), .retire_gpr(retire_gpr));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask : rd

  // one retirement, then wait until counters and interrupt have settled
  task automatic put(input retire_t r);
    @(posedge clk_sys);
    send <= 1'b1;
    ev   <= r;
    @(posedge clk_sys);
    send <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : put

  function automatic retire_t mk(input logic [8:0] f, input data_src_t s, input logic [3:0] p);
    retire_t r;
    r = '0;
    {r.home_local, r.sib_modified, r.llc_wb_mod, r.bp_dropped, r.itlb_miss,
     r.dtlb_miss, r.demand, r.is_store, r.is_load} = f;
    r.valid     = 1'b1;
    r.src       = s;
    r.presence  = p;
    r.self_core = 4'h1;
    return r;
  endfunction : mk

  // program counter 0, send one report, expect the count to reach e
  task automatic try(input logic [7:0] es, input logic [7:0] um, input retire_t r,
                     input logic e);
    wr(OFS_CFG0, {15'h0, 1'b1, um, es});
    wr(OFS_CNT0, 32'h0);
    put(r);
    rd(OFS_CNT0, {31'h0, e}, "count0");
  endtask : try

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    retire_t r;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(OFS_STATUS, 32'h0, "status reset");
    rd(OFS_CFG0, 32'h0, "cfg0 reset");
    chk("interrupt reset", 32'h0, {31'h0, perf_monitor_interrupt});
    wr(8'hfc, 32'hffff_ffff);
    rd(8'hfc, 32'h0, "unmapped");
    try(8'h0b, 8'h01, mk(9'h005, SRC_L1, 4'h1), 1'b1);
    try(8'h0b, 8'h02, mk(9'h002, SRC_L1, 4'h1), 1'b1);
    try(8'h0b, 8'h02, mk(9'h005, SRC_L1, 4'h1), 1'b0);
    try(8'hcb, 8'h01, mk(9'h005, SRC_L1, 4'h1), 1'b1);
    try(8'hcb, 8'h02, mk(9'h005, SRC_L2, 4'h1), 1'b1);
    try(8'hcb, 8'h04, mk(9'h005, SRC_LLC, 4'h1), 1'b1);
    try(8'hcb, 8'h04, mk(9'h005, SRC_LLC, 4'h3), 1'b1);
    try(8'hcb, 8'h04, mk(9'h045, SRC_LLC, 4'h2), 1'b1);
    try(8'hcb, 8'h04, mk(9'h005, SRC_LLC, 4'h2), 1'b0);
    try(8'hcb, 8'h08, mk(9'h005, SRC_LLC, 4'h2), 1'b1);
    try(8'hcb, 8'h10, mk(9'h005, SRC_LOCAL_DRAM, 4'h1), 1'b1);
    try(8'hcb, 8'h20, mk(9'h025, SRC_L1, 4'h1), 1'b1);
    try(8'hcb, 8'h40, mk(9'h005, SRC_FILL_BUF, 4'h1), 1'b1);
    try(8'hcb, 8'h80, mk(9'h009, SRC_L1, 4'h1), 1'b1);
    try(8'hcb, 8'h01, mk(9'h001, SRC_L1, 4'h1), 1'b0);
    try(8'h0f, 8'h02, mk(9'h085, SRC_LLC, 4'h2), 1'b1);
    try(8'h0f, 8'h08, mk(9'h005, SRC_REMOTE_FWD, 4'h1), 1'b1);
    try(8'h0f, 8'h10, mk(9'h005, SRC_REMOTE_DRAM, 4'h1), 1'b1);
    try(8'h0f, 8'h20, mk(9'h005, SRC_LOCAL_DRAM, 4'h1), 1'b1);
    try(8'h0f, 8'h80, mk(9'h005, SRC_UNCACHED_IO, 4'h1), 1'b1);
    try(8'h0f, 8'h20, mk(9'h105, SRC_REMOTE_HITM, 4'h1), 1'b1);
    try(8'h0f, 8'h10, mk(9'h105, SRC_REMOTE_HITM, 4'h1), 1'b0);
    try(8'h0f, 8'h10, mk(9'h005, SRC_REMOTE_HITM, 4'h1), 1'b1);
    try(8'h0c, 8'h01, mk(9'h00a, SRC_L1, 4'h1), 1'b1);
    try(8'h0c, 8'h02, mk(9'h022, SRC_L1, 4'h1), 1'b1);
    try(8'hc8, 8'h20, mk(9'h010, SRC_L1, 4'h1), 1'b1);
    rd(OFS_CFG0, 32'h0001_20c8, "cfg0");
    r = mk(9'h005, SRC_L1, 4'h1);
    r.valid = 1'b0;
    try(8'h0b, 8'h01, r, 1'b0);
    wr(OFS_CFG0, 32'h0);
    for (int i = 0; i < NUM_CNT; i++) begin
      wr(OFS_CFG0 + 8'(4 * i), {15'h0, 1'b1, 8'h01, 8'h0b});
      wr(OFS_CNT0 + 8'(4 * i), CNT_MAX);
      put(mk(9'h005, SRC_L1, 4'h1));
      rd(OFS_STATUS, (32'h1 << i) | ((i == 0) ? 32'h0 : (32'(i - 1) << 12)), "armed");
      chk("interrupt idle", 32'h0, {31'h0, perf_monitor_interrupt});
      r = mk(9'h005, SRC_L1, 4'h1);
      r.next_ip = {32'h5a00_0000 + 32'(i), 32'h0000_1000 + 32'(4 * i)};
      put(r);
      chk("interrupt", 32'h1, {31'h0, perf_monitor_interrupt});
      rd(OFS_STATUS, 32'h100 | (32'(i) << 12), "status");
      rd(OFS_IP_LO, r.next_ip[31:0], "ip lo");
      rd(OFS_IP_HI, r.next_ip[63:32], "ip hi");
      rd(OFS_GPR0, r.next_ip[31:0], "gpr0 lo");
      rd(OFS_GPR0 + 8'h78, r.next_ip[31:0] + 32'h0000_000f, "gpr15 lo");
      rd(OFS_GPR0 + 8'h7c, ~r.next_ip[31:0], "gpr15 hi");
      rd(OFS_CNT0 + 8'(4 * i), 32'h1, "count after capture");
      wr(OFS_STATUS, 32'h100);
      rd(OFS_STATUS, 32'(i) << 12, "status cleared");
      chk("interrupt cleared", 32'h0, {31'h0, perf_monitor_interrupt});
      wr(OFS_CFG0 + 8'(4 * i), 32'h0);
    end
    complete_run();
  end

  // hang guard: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end
endmodule : mem_event_sampler_tb
`default_nettype wire
